/* tb.sv */
`timescale 1ns/100ps
module tb;
  logic clk_sys, rstn, avs_read, avs_write, timer_zero_overflow, ext_pin, save_req;
  logic restore_req, powered_down, core_ack, return_from_service, avs_waitrequest;
  logic irq_take, restore_valid, wake_req;
  logic [7:0] avs_address, accumulator, program_flags, restore_acc, restore_flags, q;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [11:0] vector_pc;
  logic [1:0] stack_level_bits;
  logic [15:0] r;
  int n_mismatch, samples_checked, i, t;
  tsi_unit u_dut (.*);
  tsi_core_model u_core (.*);
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lf
  task automatic complete_run;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {avs_address, avs_write, avs_read} <= {a, w, !w};
    avs_writedata <= {24'h000000, d};
    t = 0;
    do
      @(negedge clk_sys);
    while (avs_waitrequest !== 1'b0 && ++t < 64);
    if (t >= 64)
      n_mismatch++;
    q = avs_readdata[7:0];
    @(posedge clk_sys);
    {avs_read, avs_write} <= 2'b00;
  endtask : bus
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask : rd
  task automatic await(ref logic s);
    for (t = 0; t < 60; t++)
    begin
      @(negedge clk_sys);
      if (s === 1'b1)
        break;
    end
    if (t >= 60)
      n_mismatch++;
  endtask : await
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    {avs_read, avs_write, timer_zero_overflow, ext_pin, save_req, restore_req} = '0;
    {avs_address, accumulator, program_flags, avs_writedata, powered_down, rstn} = '0;
    {avs_byteenable, r} = {4'hF, 16'hC526};
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    rd("stk", 8'hDF, 8'h03);
    rd("edge", 8'hBF, 8'h10);
    rd("req", 8'hC8, 8'h00);
    rd("hole", 8'hC0, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      r = lf(r);
      bus(1'b1, 8'hC9, r[7:0]);
      rd("en", 8'hC9, r[7:0] & 8'h21);
    end
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'hC8, 8'h00);
      bus(1'b1, 8'hBF, {3'b000, i[1:0], 3'b000});
      ext_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd("rise", 8'hC8, {7'h00, i[0]});
      bus(1'b1, 8'hC8, 8'h00);
      ext_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd("fall", 8'hC8, {7'h00, i[1]});
    end
    bus(1'b1, 8'hC8, 8'h00);
    bus(1'b1, 8'hC9, 8'h20);
    timer_zero_overflow <= 1'b1;
    @(posedge clk_sys);
    timer_zero_overflow <= 1'b0;
    rd("tmr", 8'hC8, 8'h20);
    bus(1'b1, 8'hDF, 8'h83);
    await(irq_take);
    chk("pc", 12'h008, vector_pc);
    rd("gie", 8'hDF, 8'h02);
    bus(1'b1, 8'hC8, 8'h00);
    repeat (50) @(posedge clk_sys);
    rd("gie", 8'hDF, 8'h83);
    for (i = 0; i < 2; i++)
    begin
      r = lf(r);
      @(posedge clk_sys);
      {accumulator, program_flags, save_req} <= {r, 1'b1};
      @(posedge clk_sys);
      save_req <= 1'b0;
    end
    restore_req <= 1'b1;
    @(posedge clk_sys);
    restore_req <= 1'b0;
    await(restore_valid);
    chk("acc", r[15:8], restore_acc);
    chk("flg", r[7:0] & 8'h3F, restore_flags);
    {powered_down, ext_pin} <= 2'b11;
    await(wake_req);
    chk("wake", 1'b1, wake_req);
    complete_run();
  end
endmodule : tb

/* tsi_core_model.sv */
`timescale 1ns/100ps
module tsi_core_model
#(
  parameter int DLY = 40
)(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Unit side.
  input wire logic irq_take,
  output logic core_ack,
  output logic return_from_service
);
  int cnt;
  always @(posedge clk_sys or negedge rstn)
  begin
    return_from_service <= 1'b0;
    core_ack <= rstn;
    if (!rstn)
      cnt <= 0;
    else if (irq_take === 1'b1)
      cnt <= DLY;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      return_from_service <= (cnt == 1);
    end
  end
endmodule : tsi_core_model

/* tsi_defs.svh */
`ifndef TSI_DEFS_SVH
`define TSI_DEFS_SVH
// Overview of operation
// - Two request sources only: timer zero overflow and the external pin.
// - Taking an interrupt clears the global enable.
// - Return from service sets the global enable again.
// - Taking an interrupt lowers the stack level bits by one and jumps to vector 8.
// - Enable mask bit 0 gates the external pin request, reset 0, RW.
// - Enable mask bit 5 gates the timer request, reset 0, RW.
// - A source event sets its request flag.
// - Flags stay set until software clears them by a write.
// - Request flags sit at bit 0 (pin) and bit 5 (timer), reset 0, RW.
// - Global enable is bit 7 of the stack register, reset 0, gates all.
// - A pin trigger sets its flag even while its enable is 0.
// - Vectoring needs a set flag together with its set enable bit.
// - Timer overflow sets its flag regardless of its enable.
// - Edge field bits 4:3: 01 rising, 10 falling, 11 both, 00 reserved.
// - Save copies accumulator and flags, restore reloads; two flag bits excluded.
// - The save buffer is one entry; a second save overwrites it.
// - An external pin event wakes the chip from power-down.
// - Port 0 wakeup is always enabled, with no software enable bit.
`define TSI_OFS_EDGE 8'hBF
`define TSI_OFS_REQ 8'hC8
`define TSI_OFS_EN 8'hC9
`define TSI_OFS_STK 8'hDF
`define TSI_BIT_PIN 0
`define TSI_BIT_TMR 5
`define TSI_BIT_GIE 7
`define TSI_EDGE_LO 3
`define TSI_EDGE_HI 4
`define TSI_VECTOR 12'h008
`define TSI_STK_RST 2'h3
`define TSI_EDGE_RST 2'h2
`define TSI_FLAG_KEEP 8'h3F
`endif

/* tsi_pkg.sv */
package tsi_pkg;
  typedef enum logic [1:0] {TSI_IDLE, TSI_DONE} tsi_bus_st_t;
  typedef struct packed {
    logic [1:0] edge_sel;
    logic pin_en;
    logic tmr_en;
    logic pin_flag;
    logic tmr_flag;
    logic global_irq_enable;
    logic [1:0] stk;
    logic [7:0] save_acc;
    logic [7:0] save_flags;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    tsi_bus_st_t bus_st;
    logic [31:0] rdata;
    logic take;
    logic [11:0] pc;
    logic [7:0] acc_out;
    logic [7:0] flags_out;
    logic restore;
    logic wake;
  } tsi_state_t;
endpackage : tsi_pkg

/* tsi_properties.sv */
`timescale 1ns/100ps
module tsi_properties
  import tsi_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Observed ports.
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic ext_pin,
  input wire logic powered_down,
  input wire logic restore_req,
  input wire logic irq_take,
  input wire logic [11:0] vector_pc,
  input wire logic [1:0] stack_level_bits,
  input wire logic restore_valid,
  input wire logic wake_req
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  property p_vec; irq_take |-> vector_pc == 12'h008; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_stk; irq_take |-> stack_level_bits == $past(stack_level_bits) - 2'h1; endproperty
  a_stk: assert property (p_stk) else $error("bad stack");
  property p_once; irq_take |=> !irq_take; endproperty
  a_once: assert property (p_once) else $error("second take");
  property p_ans; $rose(avs_read) |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_wp; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wp: assert property (p_wp) else $error("long answer");
  property p_rdz; !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000; endproperty
  a_rdz: assert property (p_rdz) else $error("upper data");
  property p_wake; powered_down && $changed(ext_pin) |-> ##[1:5] wake_req; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_rv; restore_req |-> ##[1:2] restore_valid; endproperty
  a_rv: assert property (p_rv) else $error("no restore");
  c_take: cover property (irq_take);
  c_wake: cover property (wake_req);
  c_rest: cover property (restore_valid);
endmodule : tsi_properties
bind tsi_unit tsi_properties u_props (.*);

/* tsi_unit.sv */
`timescale 1ns/100ps
`include "tsi_defs.svh"
module tsi_unit
  import tsi_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PC_W = 12
)(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sources.
  input wire logic timer_zero_overflow,
  input wire logic ext_pin,
  // Core side.
  input wire logic core_ack,
  input wire logic return_from_service,
  input wire logic save_req,
  input wire logic restore_req,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] program_flags,
  input wire logic powered_down,
  output logic irq_take,
  output logic [PC_W-1:0] vector_pc,
  output logic [1:0] stack_level_bits,
  output logic [7:0] restore_acc,
  output logic [7:0] restore_flags,
  output logic restore_valid,
  output logic wake_req
);
  initial
  begin
    if (ADDR_W < 8 || PC_W != 12)
      $error("Unsupported parameters.");
  end

  tsi_state_t s_q, s_d;
  logic pin_rise, pin_fall, pin_evt, wr, rd, pend;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    s_d = s_q;
    s_d.pin_s1 = ext_pin;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    pin_rise = s_q.pin_s2 & ~s_q.pin_s3;
    pin_fall = ~s_q.pin_s2 & s_q.pin_s3;
    pin_evt = 1'b0;
    unique case (s_q.edge_sel)
      2'b01: pin_evt = pin_rise;
      2'b10: pin_evt = pin_fall;
      2'b11: pin_evt = pin_rise | pin_fall;
      2'b00: pin_evt = 1'b0;
    endcase
    wr = avs_write & (s_q.bus_st == TSI_IDLE) & avs_byteenable[0];
    rd = avs_read & (s_q.bus_st == TSI_IDLE);
    s_d.bus_st = (avs_read | avs_write) && s_q.bus_st == TSI_IDLE ? TSI_DONE : TSI_IDLE;
    if (rd)
    begin
      s_d.rdata = 32'h0;
      unique case (avs_address[7:0])
        `TSI_OFS_EDGE: s_d.rdata[`TSI_EDGE_HI:`TSI_EDGE_LO] = s_q.edge_sel;
        `TSI_OFS_EN:
        begin
          s_d.rdata[`TSI_BIT_PIN] = s_q.pin_en;
          s_d.rdata[`TSI_BIT_TMR] = s_q.tmr_en;
        end
        `TSI_OFS_REQ:
        begin
          s_d.rdata[`TSI_BIT_PIN] = s_q.pin_flag;
          s_d.rdata[`TSI_BIT_TMR] = s_q.tmr_flag;
        end
        `TSI_OFS_STK:
        begin
          s_d.rdata[`TSI_BIT_GIE] = s_q.global_irq_enable;
          s_d.rdata[1:0] = s_q.stk;
        end
        default: s_d.rdata = 32'h0;
      endcase
    end
    if (wr)
    begin
      unique case (avs_address[7:0])
        `TSI_OFS_EDGE: s_d.edge_sel = avs_writedata[`TSI_EDGE_HI:`TSI_EDGE_LO];
        `TSI_OFS_EN:
        begin
          s_d.pin_en = avs_writedata[`TSI_BIT_PIN];
          s_d.tmr_en = avs_writedata[`TSI_BIT_TMR];
        end
        `TSI_OFS_REQ:
        begin
          s_d.pin_flag = avs_writedata[`TSI_BIT_PIN];
          s_d.tmr_flag = avs_writedata[`TSI_BIT_TMR];
        end
        `TSI_OFS_STK:
        begin
          s_d.global_irq_enable = avs_writedata[`TSI_BIT_GIE];
          s_d.stk = avs_writedata[1:0];
        end
        default: s_d.rdata = s_q.rdata;
      endcase
    end
    if (pin_evt)
      s_d.pin_flag = 1'b1;
    if (timer_zero_overflow)
      s_d.tmr_flag = 1'b1;
    pend = (s_q.pin_flag & s_q.pin_en) | (s_q.tmr_flag & s_q.tmr_en);
    s_d.take = 1'b0;
    if (s_q.global_irq_enable && pend && core_ack && !s_q.take)
    begin
      s_d.take = 1'b1;
      s_d.global_irq_enable = 1'b0;
      s_d.stk = s_q.stk - 2'h1;
      s_d.pc = `TSI_VECTOR;
    end
    else if (return_from_service)
    begin
      s_d.global_irq_enable = 1'b1;
      s_d.stk = s_q.stk + 2'h1;
    end
    if (save_req)
    begin
      s_d.save_acc = accumulator;
      s_d.save_flags = program_flags & `TSI_FLAG_KEEP;
    end
    s_d.restore = restore_req;
    if (restore_req)
    begin
      s_d.acc_out = s_q.save_acc;
      s_d.flags_out = s_q.save_flags;
    end
    s_d.wake = powered_down & (s_q.pin_s2 ^ s_q.pin_s3);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.stk <= `TSI_STK_RST;
      s_q.edge_sel <= `TSI_EDGE_RST;
      s_q.bus_st <= TSI_IDLE;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = ~(s_q.bus_st == TSI_DONE);
  assign irq_take = s_q.take;
  assign vector_pc = s_q.pc;
  assign stack_level_bits = s_q.stk;
  assign restore_acc = s_q.acc_out;
  assign restore_flags = s_q.flags_out;
  assign restore_valid = s_q.restore;
  assign wake_req = s_q.wake;
endmodule : tsi_unit
